// >>> src/dhw_pkg.sv
// Shared constants, types and state codes for the DAC host write port
package dhw_pkg;
    // Channel space
    localparam int CHAN_W = 6;
    localparam int SEL_W = 2;
    localparam int DATA_W = 12;
    localparam logic [5:0] CHAN_FIRST = 6'h00;
    localparam logic [5:0] CHAN_LAST = 6'h27;
    localparam logic [5:0] CHAN_STEP = 6'h01;
    localparam int FIFO_DEPTH = 8;
    // Two-wire bus address: fixed upper part, two strap bits below
    localparam logic [4:0] BUS_ADDR_FIXED = 5'h15;
    localparam logic [7:0] PTR_BURST = 8'hff;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    // Field positions of the two data bytes
    localparam int DB_SEL_HI = 7;
    localparam int DB_SEL_LO = 6;
    localparam int DB_MSN_HI = 3;
    // Shift-register word of the four-wire link
    localparam int SW_W = 24;
    localparam logic [4:0] SW_COUNT = 5'h18;
    localparam logic [4:0] SW_STEP = 5'h01;
    localparam logic [4:0] SW_ZERO = 5'h00;
    localparam int SW_RW = 22;
    localparam int SW_CH_HI = 21;
    localparam int SW_CH_LO = 16;
    localparam int SW_SEL_HI = 15;
    localparam int SW_SEL_LO = 14;

    // One register write bound for a channel
    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic [SEL_W-1:0] sel;
        logic [DATA_W-1:0] data;
    } dhw_word_t;

    // Parallel port pins
    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic [CHAN_W-1:0] chan;
        logic [SEL_W-1:0] sel;
        logic [DATA_W-1:0] data;
    } dhw_par_t;

    // Byte-level states of the two-wire receiver
    typedef enum logic [5:0] {
        TW_IDLE = 6'h01,
        TW_ADDR = 6'h02,
        TW_PTR = 6'h04,
        TW_DHI = 6'h08,
        TW_DLO = 6'h10,
        TW_SKIP = 6'h20
    } dhw_tw_state_t;
endpackage

// >>> src/dhw_fifo.sv
// Parameterised FIFO with registered output stage
`timescale 1ns/1ns
`default_nettype none
module dhw_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_MAX = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
    localparam logic [AW-1:0] PTR_ONE = AW'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic ov_reg, ov_next;
    logic [WIDTH-1:0] od_reg, od_next;
    logic push, pop;

    // The output stage counts toward the depth: at most DEPTH words wait
    assign in_ready = ((cnt_reg + (AW+1)'(ov_reg)) != CNT_MAX);
    assign out_valid = ov_reg;
    assign out_data = od_reg;

    // Pop moves a word into the output stage whenever it is free
    always_comb begin
        push = in_valid && in_ready;
        pop = (cnt_reg != '0) && (!ov_reg || out_ready);
        wptr_next = push ? wptr_reg + PTR_ONE : wptr_reg;
        rptr_next = pop ? rptr_reg + PTR_ONE : rptr_reg;
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + CNT_ONE;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - CNT_ONE;
        end
        ov_next = ov_reg && !out_ready;
        od_next = od_reg;
        if (pop) begin
            ov_next = 1'b1;
            od_next = mem[rptr_reg];
        end
    end

    // Storage has no reset; occupancy alone says what is valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
            ov_reg <= 1'b0;
            od_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg <= cnt_next;
            ov_reg <= ov_next;
            od_reg <= od_next;
        end
    end
endmodule
`default_nettype wire

// >>> src/dhw_port.sv
// Host write port: two-wire, four-wire and parallel paths into a FIFO
//
// What this block does
// - Device acknowledges a matching write address by pulling data low.
// - Pointer byte 0xff after the address starts auto-increment burst.
// - Entering burst sets the channel pointer to channel 0.
// - Each two-byte data word in burst advances the pointer by one.
// - Select bits inside the data bytes pick the channel register.
// - After channel 39 in burst, fall back to pointer-per-update operation.
// - A STOP anywhere ends burst mode at once.
// - Toggle operation is not allowed while burst is active.
// - Interface select low enables parallel port, disables serial links.
// - Parallel device select is active low; writes only while asserted.
// - Write strobe rising edge with select low captures channel address.
// - Same strobe edge loads the data bus into the chosen register.
// - Two select inputs choose the destination register of the write.
// - Parallel data is straight 12-bit binary, top line the MSB.
// - All 40 channels are individually addressable.
// - Serial output shifts on clock rise, input latches on clock fall.
// - Hardware reset reloads every register with its default.
// - Outputs stay held at zero volts until a valid write occurs.
// - Respond only to bus address 10101 plus the two strap bits.
// - Pointer-per-update: pointer byte then two data bytes, address once.
// - Acknowledge each address and data byte during the ninth clock.
`timescale 1ns/1ns
`default_nettype none
module dhw_port (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Mode pins
    input wire logic interface_select,
    input wire logic two_wire_select,
    input wire logic bus_addr_strap_hi,
    input wire logic bus_addr_strap_lo,
    // Two-wire link
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Four-wire link
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic din_i,
    output logic dout_o,
    // Parallel port
    input wire dhw_pkg::dhw_par_t par_i,
    // Register writes towards the channel registers
    output logic wr_valid,
    input wire logic wr_ready,
    output dhw_pkg::dhw_word_t wr_word,
    // Status
    output logic busy,
    output logic burst_active,
    output logic toggle_allowed,
    output logic outputs_released
);
    import dhw_pkg::*;

    // Two-flop synchronisers for every pin; stage 1 feeds only stage 2
    localparam int PIN_W = 10 + $bits(dhw_par_t);
    logic [PIN_W-1:0] pin_raw, pin_s1_reg, pin_s2_reg, pin_s3_reg;
    assign pin_raw = {interface_select, two_wire_select, bus_addr_strap_hi,
                      bus_addr_strap_lo, scl_i, sda_i, sclk_i, sync_n_i,
                      din_i, 1'b0, par_i};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // Decoded synchronised pins; s3 is the previous value for edges
    logic par_en, tw_en, fw_en;
    logic scl, sda, scl_d, sda_d, sclk, sclk_d, sync_n, sync_n_d, din;
    logic [1:0] strap;
    dhw_par_t par, par_d;
    always_comb begin
        par_en = !pin_s2_reg[PIN_W-1];
        tw_en = !par_en && pin_s2_reg[PIN_W-2];
        fw_en = !par_en && !pin_s2_reg[PIN_W-2];
        strap = pin_s2_reg[PIN_W-3 -: 2];
        scl = pin_s2_reg[PIN_W-5];
        sda = pin_s2_reg[PIN_W-6];
        sclk = pin_s2_reg[PIN_W-7];
        sync_n = pin_s2_reg[PIN_W-8];
        din = pin_s2_reg[PIN_W-9];
        scl_d = pin_s3_reg[PIN_W-5];
        sda_d = pin_s3_reg[PIN_W-6];
        sclk_d = pin_s3_reg[PIN_W-7];
        sync_n_d = pin_s3_reg[PIN_W-8];
        par = dhw_par_t'(pin_s2_reg[$bits(dhw_par_t)-1:0]);
        par_d = dhw_par_t'(pin_s3_reg[$bits(dhw_par_t)-1:0]);
    end

    // Two-wire bus events
    logic scl_rise, scl_fall, tw_start, tw_stop;
    always_comb begin
        scl_rise = scl && !scl_d;
        scl_fall = !scl && scl_d;
        tw_start = tw_en && scl && scl_d && sda_d && !sda;
        tw_stop = tw_en && scl && scl_d && !sda_d && sda;
    end

    // Two-wire receiver state
    dhw_tw_state_t st_reg, st_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next, hi_reg, hi_next;
    logic [5:0] ptr_reg, ptr_next;
    logic burst_reg, burst_next, ack_reg, ack_next, oe_reg, oe_next;
    logic tw_push;
    dhw_word_t tw_word;
    logic [7:0] byte_in;

    // Bit counter, byte decode, pointer and burst handling
    always_comb begin
        st_next = st_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        hi_next = hi_reg;
        ptr_next = ptr_reg;
        burst_next = burst_reg;
        ack_next = ack_reg;
        oe_next = oe_reg;
        tw_push = 1'b0;
        tw_word = '0;
        byte_in = {sh_reg[6:0], sda};
        if (!tw_en) begin
            st_next = TW_IDLE;
            burst_next = 1'b0;
            oe_next = 1'b0;
        end else if (tw_stop) begin
            st_next = TW_IDLE;
            burst_next = 1'b0;
            oe_next = 1'b0;
        end else if (tw_start) begin
            st_next = TW_ADDR;
            bit_next = BIT_ZERO;
            burst_next = 1'b0;
            oe_next = 1'b0;
        end else if (scl_fall) begin
            // Hold the line low over the ninth clock only
            oe_next = (bit_reg == BIT_ACK) && ack_reg;
        end else if (scl_rise && st_reg != TW_IDLE) begin
            if (bit_reg == BIT_ACK) begin
                bit_next = BIT_ZERO;
            end else begin
                sh_next = byte_in;
                bit_next = bit_reg + BIT_STEP;
            end
            if (bit_reg == BIT_LAST) begin
                ack_next = 1'b1;
                case (st_reg)
                    TW_ADDR: begin
                        // Receive only: a read address is not answered
                        if (byte_in[7:1] == {BUS_ADDR_FIXED, strap} &&
                            !byte_in[0]) begin
                            st_next = TW_PTR;
                        end else begin
                            st_next = TW_SKIP;
                            ack_next = 1'b0;
                        end
                    end
                    TW_PTR: begin
                        if (byte_in == PTR_BURST) begin
                            burst_next = 1'b1;
                            ptr_next = CHAN_FIRST;
                        end else begin
                            ptr_next = byte_in[5:0];
                        end
                        st_next = TW_DHI;
                    end
                    TW_DHI: begin
                        hi_next = byte_in;
                        st_next = TW_DLO;
                    end
                    TW_DLO: begin
                        tw_word.chan = ptr_reg;
                        tw_word.sel = hi_reg[DB_SEL_HI:DB_SEL_LO];
                        tw_word.data = {hi_reg[DB_MSN_HI:0], byte_in};
                        tw_push = 1'b1;
                        if (burst_reg && ptr_reg != CHAN_LAST) begin
                            ptr_next = ptr_reg + CHAN_STEP;
                            st_next = TW_DHI;
                        end else begin
                            burst_next = 1'b0;
                            st_next = TW_PTR;
                        end
                    end
                    default: begin
                        ack_next = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= TW_IDLE;
            bit_reg <= BIT_ZERO;
            sh_reg <= '0;
            hi_reg <= '0;
            ptr_reg <= CHAN_FIRST;
            burst_reg <= 1'b0;
            ack_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            hi_reg <= hi_next;
            ptr_reg <= ptr_next;
            burst_reg <= burst_next;
            ack_reg <= ack_next;
            oe_reg <= oe_next;
        end
    end

    // Four-wire link: in on the falling edge, out on the rising edge
    logic [SW_W-1:0] sw_reg, sw_next;
    logic [4:0] swc_reg, swc_next;
    logic dout_reg, dout_next, fw_push;
    dhw_word_t fw_word;
    always_comb begin
        sw_next = sw_reg;
        swc_next = swc_reg;
        dout_next = dout_reg;
        fw_push = 1'b0;
        fw_word.chan = sw_reg[SW_CH_HI:SW_CH_LO];
        fw_word.sel = sw_reg[SW_SEL_HI:SW_SEL_LO];
        fw_word.data = sw_reg[DATA_W-1:0];
        if (!fw_en || sync_n) begin
            swc_next = SW_ZERO;
            // A short frame is dropped; reads are not served here
            if (fw_en && !sync_n_d && swc_reg == SW_COUNT) begin
                fw_push = !sw_reg[SW_RW];
            end
        end else if (!sclk && sclk_d) begin
            sw_next = {sw_reg[SW_W-2:0], din};
            if (swc_reg != SW_COUNT) begin
                swc_next = swc_reg + SW_STEP;
            end
        end else if (sclk && !sclk_d) begin
            dout_next = sw_reg[SW_W-1];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sw_reg <= '0;
            swc_reg <= SW_ZERO;
            dout_reg <= 1'b0;
        end else begin
            sw_reg <= sw_next;
            swc_reg <= swc_next;
            dout_reg <= dout_next;
        end
    end

    // Parallel port: write on strobe rise with select low
    logic par_push;
    dhw_word_t par_word;
    always_comb begin
        par_push = par_en && par.wr_n && !par_d.wr_n && !par.cs_n;
        par_word.chan = par_d.chan;
        par_word.sel = par_d.sel;
        par_word.data = par_d.data;
    end

    // Merge the active path into the FIFO; channels past the last drop
    logic push_any, fifo_in_ready, fifo_in_valid;
    dhw_word_t push_word;
    always_comb begin
        push_any = par_push || tw_push || fw_push;
        push_word = par_push ? par_word : (tw_push ? tw_word : fw_word);
        fifo_in_valid = push_any && push_word.chan <= CHAN_LAST;
    end

    logic fifo_out_valid;
    logic [$bits(dhw_word_t)-1:0] fifo_out_data;
    dhw_fifo #(
        .WIDTH($bits(dhw_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(fifo_out_valid),
        .out_ready(wr_ready),
        .out_data(fifo_out_data)
    );

    // Status flags; outputs leave zero only after the first accepted write
    logic busy_reg, busy_next, rel_reg, rel_next, tog_reg, tog_next;
    always_comb begin
        busy_next = !fifo_in_ready;
        tog_next = !burst_next;
        rel_next = rel_reg || (fifo_in_valid && fifo_in_ready);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
            rel_reg <= 1'b0;
            tog_reg <= 1'b1;
        end else begin
            busy_reg <= busy_next;
            rel_reg <= rel_next;
            tog_reg <= tog_next;
        end
    end

    // Output drive; the bus line is open drain so only the enable moves
    assign sda_o = 1'b0;
    assign sda_oe = oe_reg;
    assign dout_o = dout_reg;
    assign wr_valid = fifo_out_valid;
    assign wr_word = dhw_word_t'(fifo_out_data);
    assign busy = busy_reg;
    assign burst_active = burst_reg;
    assign toggle_allowed = tog_reg;
    assign outputs_released = rel_reg;
endmodule
`default_nettype wire

// >>> bench/dhw_port_properties.sv
// Timing and protocol checker for the host write port
`timescale 1ns/1ns
`default_nettype none
module dhw_port_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pins
    input wire logic interface_select,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Write stream
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire dhw_pkg::dhw_word_t wr_word,
    // Status
    input wire logic busy,
    input wire logic burst_active,
    input wire logic toggle_allowed,
    input wire logic outputs_released
);
    import dhw_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // Bus events on the pins; the port sees them a few flops later
    sequence stop_seen;
        scl_i && $rose(sda_i);
    endsequence
    sequence ack_on;
        $rose(sda_oe);
    endsequence
    sequence ack_off;
        $fell(sda_oe);
    endsequence
    // Status flags and bus pull
    toggle_block_a: assert property (toggle_allowed == !burst_active)
        else $error("toggle allowed while burst on");
    stop_ends_a: assert property (stop_seen |-> ##[1:8] !burst_active)
        else $error("burst survived a stop");
    burst_serial_a: assert property ($rose(burst_active) |-> interface_select)
        else $error("burst began in parallel mode");
    par_quiet_a: assert property (
        !interface_select && !$past(interface_select) &&
        !$past(interface_select, 2) && !$past(interface_select, 3)
        |-> !sda_oe)
        else $error("bus driven in parallel mode");
    ack_low_a: assert property (ack_on |-> !scl_i)
        else $error("acknowledge began with clock high");
    ack_end_a: assert property (ack_off |-> !scl_i)
        else $error("acknowledge ended with clock high");
    sda_pull_a: assert property (sda_oe |-> !sda_o)
        else $error("acknowledge does not pull low");
    // Write stream holds and ranges
    word_hold_a: assert property (
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
        else $error("word dropped before taken");
    chan_range_a: assert property (wr_valid |-> wr_word.chan <= CHAN_LAST)
        else $error("word for missing channel");
    released_keep_a: assert property (outputs_released |=> outputs_released)
        else $error("outputs held again without reset");
    valid_release_a: assert property (wr_valid |-> outputs_released)
        else $error("word seen while outputs held");
endmodule

bind dhw_port dhw_port_properties u_props (.clk(clk), .nrst(nrst),
    .interface_select(interface_select), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_word(wr_word), .busy(busy),
    .burst_active(burst_active), .toggle_allowed(toggle_allowed),
    .outputs_released(outputs_released));
`default_nettype wire

// >>> bench/dhw_host.sv
// Two-wire bus master model, 160 ns bit period
`timescale 1ns/1ns
`default_nettype none
module dhw_host (
    // Clock
    input wire logic clk,
    // Bus lines; data is open drain, released means pulled high
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    // Idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Lines move only at the falling system edge
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Data falls while clock is high; also serves as repeated start
    task automatic start();
        sda_m = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_m = 1'b0;
        tick(4);
        scl = 1'b0;
        tick(2);
    endtask
    // Data rises while clock is high; clock then stands still
    task automatic stop();
        sda_m = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_m = 1'b1;
        tick(4);
    endtask
    // Data changes only while clock is low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        sda_m = b;
        tick(2);
        scl = 1'b1;
        tick(2);
        s = sda;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask
    // Eight bits then a released ninth clock for the answer
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, ack);
    endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the host write port
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dhw_pkg::*;
    logic clk = 1'b0;
    logic nrst, isel, st_hi, st_lo, wr_ready, stall, rel, tog, burst;
    logic wr_valid, busy, sda_o, sda_oe;
    logic tws, sclk, sync_n, din, dout;
    logic [23:0] fw_prev = '0;
    wire logic scl, sda_m, sda;
    dhw_par_t par;
    dhw_word_t wr_word;
    dhw_word_t exp_q[$];
    int err_count = 0;
    int comparisons = 0;
    int seed = 32'h1502a8a3;
    // Wired-and of master and port pull-down
    assign sda = sda_m & ~(sda_oe & ~sda_o);
    always #10 clk = ~clk;
    dhw_host u_host (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));
    dhw_port u_dut (.clk(clk), .nrst(nrst), .interface_select(isel),
        .two_wire_select(tws), .bus_addr_strap_hi(st_hi),
        .bus_addr_strap_lo(st_lo), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .sclk_i(sclk), .sync_n_i(sync_n), .din_i(din),
        .dout_o(dout), .par_i(par), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_word(wr_word), .busy(busy), .burst_active(burst),
        .toggle_allowed(tog), .outputs_released(rel));
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Consumer stalls at random, or fully while a fill is wanted
    always @(negedge clk) begin
        wr_ready <= !stall && ($random(seed) % 2 != 0);
    end
    // Each taken word is matched against the oldest note
    always @(posedge clk) begin
        if (nrst === 1'b1 && wr_valid === 1'b1 && wr_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("unexpected at %0t: extra word %h", $time, wr_word);
            end else begin
                check(wr_word, exp_q.pop_front());
            end
        end
    end
    // Strobe held low 80 ns before its rising edge, high 120 ns after
    task automatic par_wr(input logic [5:0] ch, input logic [1:0] sl,
        input logic cs_n, input logic keep);
        dhw_word_t w;
        w.chan = ch;
        w.sel = sl;
        w.data = 12'($random(seed));
        par = '{cs_n: cs_n, wr_n: 1'b0, chan: ch, sel: sl, data: w.data};
        repeat (4) @(negedge clk);
        par.wr_n = 1'b1;
        if (keep) exp_q.push_back(w);
        repeat (6) @(negedge clk);
    endtask
    // Two data bytes: select bits on top, then the low data byte
    task automatic tw_word(input logic [5:0] ch);
        dhw_word_t w;
        logic a;
        w.chan = ch;
        w.sel = 2'($random(seed));
        w.data = 12'($random(seed));
        exp_q.push_back(w);
        u_host.wbyte({w.sel, 2'h0, w.data[11:8]}, a);
        check(20'(a), 20'h0);
        u_host.wbyte(w.data[7:0], a);
        check(20'(a), 20'h0);
    endtask
    task automatic tw_byte(input logic [7:0] b, input logic want);
        logic a;
        u_host.wbyte(b, a);
        check(20'(a), 20'(want));
    endtask
    task automatic drain();
        repeat (3000) if (exp_q.size() != 0) @(negedge clk);
        check(20'(exp_q.size()), 20'h0);
    endtask
    // Four-wire frame, MSB first; dout replays the previous frame
    task automatic fw_send(input logic [5:0] ch, input logic rd);
        dhw_word_t w;
        logic [23:0] f;
        w.chan = ch;
        w.sel = 2'($random(seed));
        w.data = 12'($random(seed));
        f = {1'b0, rd, w.chan, w.sel, 2'h0, w.data};
        if (!rd) exp_q.push_back(w);
        sync_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 23; i >= 0; i--) begin
            din = f[i];
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            check(20'(dout), 20'(fw_prev[i]));
            sclk = 1'b0;
            repeat (4) @(negedge clk);
        end
        sync_n = 1'b1;
        fw_prev = f;
        repeat (8) @(negedge clk);
    endtask
    initial begin
        #1000000;
        err_count++;
        conclude();
    end
    initial begin
        nrst = 1'b0;
        isel = 1'b0;
        st_hi = 1'b1;
        st_lo = 1'b0;
        stall = 1'b0;
        wr_ready = 1'b0;
        tws = 1'b1;
        sclk = 1'b0;
        sync_n = 1'b1;
        din = 1'b0;
        par = '{cs_n: 1'b1, wr_n: 1'b1, default: '0};
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        check(20'(rel), 20'h0);
        check(20'(tog), 20'h1);
        // Parallel: edges of the channel range, every select, refusals
        par_wr(CHAN_FIRST, 2'h3, 1'b0, 1'b1);
        check(20'(rel), 20'h1);
        par_wr(CHAN_LAST, 2'h1, 1'b0, 1'b1);
        par_wr(6'h05, 2'h2, 1'b1, 1'b0);
        par_wr(6'h28, 2'h2, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) par_wr(6'(i + 7), 2'(i), 1'b0, 1'b1);
        drain();
        // Fill the buffer with the consumer stalled
        stall = 1'b1;
        for (int i = 0; i < FIFO_DEPTH; i++) par_wr(6'(i), 2'h0, 1'b0, 1'b1);
        repeat (3) @(negedge clk);
        check(20'(busy), 20'h1);
        stall = 1'b0;
        drain();
        check(20'(busy), 20'h0);
        $display("test parallel done");
        // Serial mode: parallel strobes ignored, pointer per update
        isel = 1'b1;
        par_wr(6'h02, 2'h0, 1'b0, 1'b0);
        u_host.start();
        tw_byte(8'hac, 1'b0);
        tw_byte(8'h05, 1'b0);
        tw_word(6'h05);
        tw_byte(8'h27, 1'b0);
        tw_word(6'h27);
        u_host.stop();
        // Other strap setting, then a read request: both unanswered
        st_lo = 1'b1;
        u_host.start();
        tw_byte(8'hac, 1'b1);
        u_host.stop();
        st_lo = 1'b0;
        u_host.start();
        tw_byte(8'had, 1'b1);
        u_host.stop();
        $display("test three byte done");
        // Burst across all channels, then a pointer again
        u_host.start();
        tw_byte(8'hac, 1'b0);
        tw_byte(PTR_BURST, 1'b0);
        for (int i = 0; i <= 39; i++) begin
            tw_word(6'(i));
            if (i == 0) check(20'({burst, tog}), 20'h2);
        end
        check(20'(burst), 20'h0);
        tw_byte(8'h03, 1'b0);
        tw_word(6'h03);
        u_host.stop();
        // Stop in mid-burst
        u_host.start();
        tw_byte(8'hac, 1'b0);
        tw_byte(PTR_BURST, 1'b0);
        tw_word(6'h00);
        tw_word(6'h01);
        u_host.stop();
        check(20'(burst), 20'h0);
        drain();
        $display("test burst done");
        // Reset in mid-burst: burst off, outputs held at zero again
        u_host.start();
        tw_byte(8'hac, 1'b0);
        tw_byte(PTR_BURST, 1'b0);
        tw_word(6'h00);
        drain();
        nrst = 1'b0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        check(20'({burst, tog, rel}), 20'h2);
        u_host.stop();
        $display("test reset done");
        // Four-wire: two writes, then a read frame that must be dropped
        tws = 1'b0;
        repeat (4) @(negedge clk);
        fw_send(6'h11, 1'b0);
        fw_send(CHAN_LAST, 1'b0);
        fw_send(6'h02, 1'b1);
        drain();
        $display("test four wire done");
        conclude();
    end
endmodule
`default_nettype wire
